// ### obd_mem_decoder.sv
`timescale 1ns/10ps
// Notes on behaviour
// - 16 kB read-only region decoded at address zero, contents fixed.
// - read-only memory has its own arbiter and answers reads in one cycle.
// - writes to read-only memory complete normally, change nothing, raise no error.
// - main memory is four 16k-word banks plus two 1k-word banks, 264 kB.
// - each bank arbitrates alone; four masters on four banks all proceed together.
// - main memory begins at 0x20000000.
// - first 256 kB stripes words over big banks 0..3, index advancing per rotation.
// - next two 4 kB regions map onto small bank 0 then small bank 1.
// - any bank finishes a lone access in one cycle, except a cache-as-memory read right after a write.
// - non-striped mirror shows each big bank as consecutive 64 kB windows.
// - mirror base lies 16 MB above the main memory base.
// - with flash cache off, its 16 kB store is memory at 0x15000000.
// - USB data RAM, 4 kB at 0x50100000, usable as memory including fetch.
// - no bank limits content; fetches and data accesses both accepted.
// - cache-as-memory accesses fault while the flash cache is enabled.
// - cache-as-memory read right after a write takes one wait state.
module obd_mem_decoder
  import obd_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic [NM-1:0]          m_req,
  input  wire logic [NM-1:0][31:0]    m_addr,
  input  wire logic [NM-1:0]          m_write,
  input  wire logic [NM-1:0][BEW-1:0] m_be,
  input  wire logic [NM-1:0][DW-1:0]  m_wdata,
  input  wire logic                   cache_on,
  output logic      [NM-1:0]          m_done,
  output logic      [NM-1:0]          m_err,
  output logic      [NM-1:0][DW-1:0]  m_rdata
);
  logic [NM-1:0]          m_done_reg;
  logic [NM-1:0]          m_err_reg;
  logic [NM-1:0][DW-1:0]  m_rdata_reg;

  logic [NM-1:0][3:0]     tgt;
  logic [NM-1:0][IW-1:0]  idx;
  logic [NM-1:0]          bad;
  logic [NM-1:0]          granted;
  logic [NM-1:0][DW-1:0]  rd_sel;
  logic [NT-1:0][NM-1:0]  treq;
  logic [NT-1:0][NM-1:0]  tgnt;
  logic [NT-1:0][DW-1:0]  trd;
  logic [NM-1:0][XM_AW-1:0]  idx_w12;
  logic [NM-1:0][SML_AW-1:0] idx_w10;

  function automatic logic [3:0] tgt_of(input logic [31:0] a);
    if (in_win(a, ROM_BASE, ROM_LG)) return T_ROM;
    if (in_win(a, SRAM_BASE, STRIPE_LG)) return T_BIG0 + {2'h0, a[WORD_LSB +: SEL_W]};
    if (in_win(a, SML0_BASE, SML_LG)) return T_SML0;
    if (in_win(a, SML1_BASE, SML_LG)) return T_SML1;
    if (in_win(a, MIRROR_BASE, MIRROR_LG)) return T_BIG0 + {2'h0, a[BIG_LG +: SEL_W]};
    if (in_win(a, XMEM_BASE, XSEG_LG)) return T_XMEM;
    if (in_win(a, USB_BASE, USB_LG)) return T_USB;
    return T_NONE;
  endfunction : tgt_of

  function automatic logic [IW-1:0] idx_of(input logic [31:0] a);
    if (in_win(a, SRAM_BASE, STRIPE_LG)) return a[STRIPE_IX_LSB +: IW];
    return a[WORD_LSB +: IW];
  endfunction : idx_of

  // decode per master; fetch and data are treated alike
  genvar m;
  generate
    for (m = 0; m < NM; m++) begin : g_dec
      assign tgt[m]     = tgt_of(m_addr[m]);
      assign idx[m]     = idx_of(m_addr[m]);
      assign idx_w12[m] = idx[m][XM_AW-1:0];
      assign idx_w10[m] = idx[m][SML_AW-1:0];
      assign bad[m]     = (tgt[m] == T_NONE) || (tgt[m] == T_XMEM && cache_on);
      assign rd_sel[m]  = (tgt[m] < 4'(NT)) ? trd[tgt[m]] : '0;
    end
  endgenerate

  genvar t;
  generate
    for (t = 0; t < NT; t++) begin : g_req
      for (m = 0; m < NM; m++) begin : g_m
        assign treq[t][m] = m_req[m] && !bad[m] && (tgt[m] == 4'(t));
      end
    end
  endgenerate

  // one master hits at most one target, so an OR over targets is the grant
  always_comb begin
    granted = '0;
    for (int i = 0; i < NT; i++) begin
      granted = granted | tgnt[i];
    end
  end

  obd_bank #(
    .DEPTH  (ROM_DEPTH),
    .AW     (ROM_AW),
    .IS_ROM (1'b1),
    .RW_GAP (1'b0)
  ) u_rom (
    .clk     (clk),
    .sys_rst (sys_rst),
    .req     (treq[T_ROM]),
    .idx     (idx_w12),
    .wr      (m_write),
    .be      (m_be),
    .wdata   (m_wdata),
    .gnt     (tgnt[T_ROM]),
    .rd      (trd[T_ROM])
  );

  generate
    for (t = 0; t < NM; t++) begin : g_big
      obd_bank #(
        .DEPTH  (BIG_DEPTH),
        .AW     (BIG_AW),
        .IS_ROM (1'b0),
        .RW_GAP (1'b0)
      ) u_big (
        .clk     (clk),
        .sys_rst (sys_rst),
        .req     (treq[T_BIG0 + 4'(t)]),
        .idx     (idx),
        .wr      (m_write),
        .be      (m_be),
        .wdata   (m_wdata),
        .gnt     (tgnt[T_BIG0 + 4'(t)]),
        .rd      (trd[T_BIG0 + 4'(t)])
      );
    end
  endgenerate

  obd_bank #(
    .DEPTH  (SML_DEPTH),
    .AW     (SML_AW),
    .IS_ROM (1'b0),
    .RW_GAP (1'b0)
  ) u_sml0 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .req     (treq[T_SML0]),
    .idx     (idx_w10),
    .wr      (m_write),
    .be      (m_be),
    .wdata   (m_wdata),
    .gnt     (tgnt[T_SML0]),
    .rd      (trd[T_SML0])
  );

  obd_bank #(
    .DEPTH  (SML_DEPTH),
    .AW     (SML_AW),
    .IS_ROM (1'b0),
    .RW_GAP (1'b0)
  ) u_sml1 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .req     (treq[T_SML1]),
    .idx     (idx_w10),
    .wr      (m_write),
    .be      (m_be),
    .wdata   (m_wdata),
    .gnt     (tgnt[T_SML1]),
    .rd      (trd[T_SML1])
  );

  obd_bank #(
    .DEPTH  (XM_DEPTH),
    .AW     (XM_AW),
    .IS_ROM (1'b0),
    .RW_GAP (1'b1)
  ) u_xmem (
    .clk     (clk),
    .sys_rst (sys_rst),
    .req     (treq[T_XMEM]),
    .idx     (idx_w12),
    .wr      (m_write),
    .be      (m_be),
    .wdata   (m_wdata),
    .gnt     (tgnt[T_XMEM]),
    .rd      (trd[T_XMEM])
  );

  obd_bank #(
    .DEPTH  (SML_DEPTH),
    .AW     (SML_AW),
    .IS_ROM (1'b0),
    .RW_GAP (1'b0)
  ) u_usb (
    .clk     (clk),
    .sys_rst (sys_rst),
    .req     (treq[T_USB]),
    .idx     (idx_w10),
    .wr      (m_write),
    .be      (m_be),
    .wdata   (m_wdata),
    .gnt     (tgnt[T_USB]),
    .rd      (trd[T_USB])
  );

  // a stalled master sees no done until its bank grants it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      m_done_reg <= '0;
      m_err_reg  <= '0;
    end else begin
      m_done_reg <= granted | (m_req & bad);
      m_err_reg  <= m_req & bad;
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < NM; i++) begin
      if (sys_rst) m_rdata_reg[i] <= '0;
      else if (granted[i] && !m_write[i]) m_rdata_reg[i] <= rd_sel[i];
    end
  end

  assign m_done  = m_done_reg;
  assign m_err   = m_err_reg;
  assign m_rdata = m_rdata_reg;

  // checks are written for master 0 except chk_parallel, chk_stripe_m3, chk_one_winner and chk_gap_wait; the decode is shared by all masters
  chk_rom_base: assert property (@(posedge clk) disable iff (sys_rst)
    m_addr[0] < 32'h0000_4000 |-> tgt[0] == T_ROM)
    else $error("low 16 kB not decoded as read-only memory");
  chk_rom_silent: assert property (@(posedge clk) disable iff (sys_rst)
    granted[0] && m_write[0] && tgt[0] == T_ROM |=> m_done[0] && !m_err[0])
    else $error("read-only write did not complete quietly");
  chk_stripe_map: assert property (@(posedge clk) disable iff (sys_rst)
    m_addr[0][31:18] == 14'h0800 |->
      tgt[0] == T_BIG0 + {2'h0, m_addr[0][3:2]} && idx[0] == m_addr[0][17:4])
    else $error("striped word routed to wrong bank or index");
  chk_small_map: assert property (@(posedge clk) disable iff (sys_rst)
    m_addr[0][31:12] == 20'h20041 |-> tgt[0] == T_SML1 && idx_w10[0] == m_addr[0][11:2])
    else $error("second small region misrouted");
  chk_mirror_map: assert property (@(posedge clk) disable iff (sys_rst)
    m_addr[0][31:16] == 16'h2102 |-> tgt[0] == T_BIG0 + 4'h2 && idx[0] == m_addr[0][15:2])
    else $error("mirror window misrouted");
  chk_xmem_fault: assert property (@(posedge clk) disable iff (sys_rst)
    m_req[0] && cache_on && m_addr[0][31:24] == 8'h15 |=> m_done[0] && m_err[0])
    else $error("cache-as-memory access without fault while cache on");
  chk_unmapped: assert property (@(posedge clk) disable iff (sys_rst)
    m_req[0] && m_addr[0][31:24] == 8'h20 && m_addr[0][23:18] != 6'h00
      && m_addr[0][23:12] != 12'h040
      && m_addr[0][23:12] != 12'h041 |=> m_err[0])
    else $error("hole in memory segment answered without error");
  chk_parallel: assert property (@(posedge clk) disable iff (sys_rst)
    m_req == 4'hF && bad == 4'h0 && tgt[0] != tgt[1] && tgt[0] != tgt[2]
      && tgt[0] != tgt[3] && tgt[1] != tgt[2] && tgt[1] != tgt[3]
      && tgt[2] != tgt[3] && !(|(treq[T_XMEM])) |=> m_done == 4'hF)
    else $error("four masters on four banks not served together");
  chk_stall_wait: assert property (@(posedge clk) disable iff (sys_rst)
    m_req[0] && !bad[0] && !granted[0] |=> !m_done[0])
    else $error("stalled master reported done");
  chk_sram_base: assert property (@(posedge clk) disable iff (sys_rst)
    m_addr[0] == 32'h2000_0000 |-> tgt[0] == T_BIG0 && idx[0] == '0)
    else $error("main memory base not decoded as big bank 0 word 0");
  chk_small0_map: assert property (@(posedge clk) disable iff (sys_rst)
    m_addr[0][31:12] == 20'h20040 |-> tgt[0] == T_SML0 && idx_w10[0] == m_addr[0][11:2])
    else $error("first small region misrouted");
  chk_mirror_any: assert property (@(posedge clk) disable iff (sys_rst)
    m_addr[0][31:18] == 14'h0840 |->
      tgt[0] == T_BIG0 + {2'h0, m_addr[0][17:16]} && idx[0] == m_addr[0][15:2])
    else $error("mirror window does not select its own big bank");
  chk_xmem_open: assert property (@(posedge clk) disable iff (sys_rst)
    !cache_on && m_addr[0][31:24] == 8'h15 |->
      tgt[0] == T_XMEM && !bad[0] && idx_w12[0] == m_addr[0][13:2])
    else $error("cache-as-memory not decoded while cache off");
  chk_usb_map: assert property (@(posedge clk) disable iff (sys_rst)
    m_addr[0][31:12] == 20'h50100 |->
      tgt[0] == T_USB && !bad[0] && idx_w10[0] == m_addr[0][11:2])
    else $error("USB data memory not decoded");
  chk_no_kind: assert property (@(posedge clk) disable iff (sys_rst)
    m_req[0] && !bad[0] |=> !m_err[0])
    else $error("mapped access answered with a fault");
  chk_err_done: assert property (@(posedge clk) disable iff (sys_rst)
    m_err[0] |-> m_done[0])
    else $error("fault flagged without completion");
  chk_rd_capture: assert property (@(posedge clk) disable iff (sys_rst)
    granted[0] && !m_write[0] |=> m_rdata[0] == $past(rd_sel[0]))
    else $error("read data not captured in its grant cycle");
  chk_stripe_m3: assert property (@(posedge clk) disable iff (sys_rst)
    m_addr[3][31:18] == 14'h0800 |-> tgt[3] == T_BIG0 + {2'h0, m_addr[3][3:2]})
    else $error("striped word of the last master misrouted");
  chk_rom_lone: assert property (@(posedge clk) disable iff (sys_rst)
    treq[T_ROM] == 4'h1 |=> m_done[0] && !m_err[0])
    else $error("lone read-only access not finished in one cycle");

  // round robin: a waiting master sees at most three other grants first
  chk_wait_bound: assert property (@(posedge clk) disable iff (sys_rst)
    m_req[0] && !bad[0] && tgt[0] != T_XMEM |-> ##[1:4] m_done[0])
    else $error("waiting master not served within four grants");
  sequence s_same_bank;
    m_req[0] && m_req[1] && !bad[0] && !bad[1] && tgt[0] == tgt[1];
  endsequence
  chk_one_winner: assert property (@(posedge clk) disable iff (sys_rst)
    s_same_bank |=> !(m_done[0] && m_done[1]))
    else $error("two masters finished together on one bank");
  sequence s_xm_write;
    granted[0] && m_write[0] && tgt[0] == T_XMEM;
  endsequence
  chk_gap_wait: assert property (@(posedge clk) disable iff (sys_rst)
    s_xm_write ##1 (m_req[1] && !m_write[1] && tgt[1] == T_XMEM && !bad[1]) |=> !m_done[1])
    else $error("cache-as-memory read right after a write not held");
endmodule : obd_mem_decoder

// ### obd_pkg.sv
package obd_pkg;
  localparam int NM  = 4;
  localparam int MW  = 2;
  localparam int DW  = 32;
  localparam int BEW = 4;
  localparam int IW  = 14;
  localparam int NT  = 9;

  localparam logic [3:0] T_ROM  = 4'h0;
  localparam logic [3:0] T_BIG0 = 4'h1;
  localparam logic [3:0] T_SML0 = 4'h5;
  localparam logic [3:0] T_SML1 = 4'h6;
  localparam logic [3:0] T_XMEM = 4'h7;
  localparam logic [3:0] T_USB  = 4'h8;
  localparam logic [3:0] T_NONE = 4'hF;

  localparam logic [31:0] ROM_BASE    = 32'h0000_0000;
  localparam logic [31:0] SRAM_BASE   = 32'h2000_0000;
  localparam logic [31:0] SML0_BASE   = SRAM_BASE + 32'h0004_0000;
  localparam logic [31:0] SML1_BASE   = SML0_BASE + 32'h0000_1000;
  localparam logic [31:0] MIRROR_OFS  = 32'h0100_0000;
  localparam logic [31:0] MIRROR_BASE = SRAM_BASE + MIRROR_OFS;
  localparam logic [31:0] XMEM_BASE   = 32'h1500_0000;
  localparam logic [31:0] USB_BASE    = 32'h5010_0000;

  localparam int ROM_LG    = 14;
  localparam int STRIPE_LG = 18;
  localparam int SML_LG    = 12;
  localparam int MIRROR_LG = 18;
  localparam int BIG_LG    = 16;
  localparam int XSEG_LG   = 24;
  localparam int USB_LG    = 12;
  localparam int WORD_LSB  = 2;
  localparam int SEL_W     = 2;
  localparam int STRIPE_IX_LSB = WORD_LSB + SEL_W;

  localparam int BIG_DEPTH = 16384;
  localparam int SML_DEPTH = 1024;
  localparam int ROM_DEPTH = 4096;
  localparam int XM_DEPTH  = 4096;
  localparam int BIG_AW    = 14;
  localparam int SML_AW    = 10;
  localparam int ROM_AW    = 12;
  localparam int XM_AW     = 12;

  // arbitrary fill pattern standing in for mask-programmed contents
  localparam logic [31:0] ROM_SEED = 32'h5A3C_0000;

  function automatic logic in_win(input logic [31:0] a, input logic [31:0] b, input int lg);
    return ((a ^ b) >> lg) == 32'h0000_0000;
  endfunction : in_win
endpackage : obd_pkg

// ### obd_bank.sv
`timescale 1ns/10ps
module obd_bank
  import obd_pkg::*;
#(
  parameter int DEPTH  = 1024,
  parameter int AW     = 10,
  parameter bit IS_ROM = 1'b0,
  parameter bit RW_GAP = 1'b0
) (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic [NM-1:0]           req,
  input  wire logic [NM-1:0][AW-1:0]   idx,
  input  wire logic [NM-1:0]           wr,
  input  wire logic [NM-1:0][BEW-1:0]  be,
  input  wire logic [NM-1:0][DW-1:0]   wdata,
  output logic      [NM-1:0]           gnt,
  output logic      [DW-1:0]           rd
);
  logic [MW-1:0] ptr_reg;
  logic          last_wr_reg;
  logic [NM-1:0] elig;
  logic [MW-1:0] win;
  logic          any_gnt;

  function automatic logic [NM-1:0] rr_pick(input logic [NM-1:0] r, input logic [MW-1:0] p);
    logic [NM-1:0] g;
    logic [MW-1:0] j;
    g = '0;
    for (int k = NM - 1; k >= 0; k--) begin
      j = p + MW'(k);
      if (r[j]) g = NM'(1) << j;
    end
    return g;
  endfunction : rr_pick

  function automatic logic [MW-1:0] enc(input logic [NM-1:0] g);
    logic [MW-1:0] e;
    e = '0;
    for (int k = 0; k < NM; k++) begin
      if (g[k]) e = MW'(k);
    end
    return e;
  endfunction : enc

  // no write forwarding: a read right behind a write waits one cycle
  assign elig    = (RW_GAP && last_wr_reg) ? (req & wr) : req;
  assign gnt     = rr_pick(elig, ptr_reg);
  assign any_gnt = |gnt;
  assign win     = enc(gnt);

  // rotating priority so a stalled master is served within NM grants
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ptr_reg     <= '0;
      last_wr_reg <= 1'b0;
    end else begin
      if (any_gnt) ptr_reg <= win + MW'(1);
      last_wr_reg <= any_gnt && wr[win];
    end
  end

  generate
    if (IS_ROM) begin : g_rom
      assign rd = ROM_SEED ^ DW'(idx[win]);
    end else begin : g_ram
      logic [DW-1:0] mem [DEPTH];
      assign rd = mem[idx[win]];
      always_ff @(posedge clk) begin
        for (int b = 0; b < BEW; b++) begin
          if (any_gnt && wr[win] && be[win][b]) mem[idx[win]][8*b +: 8] <= wdata[win][8*b +: 8];
        end
      end
    end
  endgenerate

  chk_one_grant: assert property (@(posedge clk) disable iff (sys_rst) $onehot0(gnt))
    else $error("bank granted more than one master");
  chk_lone_served: assert property (@(posedge clk) disable iff (sys_rst)
    $onehot(req) && !(RW_GAP && last_wr_reg) |-> gnt == req)
    else $error("lone requester not served in its cycle");

  sequence s_wr_then_rd;
    (RW_GAP && any_gnt && wr[win]) ##1 ($onehot(req) && !(|(req & wr)));
  endsequence
  chk_read_gap: assert property (@(posedge clk) disable iff (sys_rst)
    s_wr_then_rd |-> gnt == '0 ##1 (req == $past(req) ? gnt == req : 1'b1))
    else $error("read after write not delayed by exactly one cycle");
endmodule : obd_bank

// ### obd_master_model.sv
`timescale 1ns/10ps
module obd_master_model
  import obd_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire logic           start,
  input  wire logic [31:0]    s_addr,
  input  wire logic           s_write,
  input  wire logic [BEW-1:0] s_be,
  input  wire logic [DW-1:0]  s_wdata,
  input  wire logic           done,
  input  wire logic           err,
  input  wire logic [DW-1:0]  rdata,
  output logic                req,
  output logic [31:0]         addr,
  output logic                write,
  output logic [BEW-1:0]      be,
  output logic [DW-1:0]       wdata,
  output logic                got_err,
  output logic [DW-1:0]       got_rdata
);
  // falling-edge updates keep the request settled before the taking edge and
  // drop it inside the done cycle, so the access is not repeated
  always @(negedge clk) begin
    if (sys_rst) begin
      req <= 1'b0;
      addr <= 32'h0000_0000;
      write <= 1'b0;
      be <= 4'h0;
      wdata <= 32'h0000_0000;
      got_err <= 1'b0;
      got_rdata <= 32'h0000_0000;
    end else if (req && done) begin
      req <= 1'b0;
      addr <= ~addr;
      write <= ~write;
      be <= ~be;
      wdata <= ~wdata;
      got_err <= err;
      got_rdata <= rdata;
    end else if (start && !req) begin
      req <= 1'b1;
      addr <= s_addr;
      write <= s_write;
      be <= s_be;
      wdata <= s_wdata;
    end
  end
endmodule : obd_master_model

// ### onchip_memory_bank_decoder_test.sv
`timescale 1ns/10ps
module onchip_memory_bank_decoder_test;
  import obd_pkg::*;
  typedef struct packed {
    logic        cache;
    logic        wr;
    logic [31:0] addr;
    logic [3:0]  be;
    logic [31:0] wd;
    logic        err;
    logic [31:0] rd;
  } obd_row_s;
  localparam int NROW = 24;
  localparam obd_row_s ROWS [NROW] = '{
    '{1'b0, 1'b1, 32'h2000_0000, 4'hF, 32'h1111_1111, 1'b0, 32'h0},
    '{1'b0, 1'b1, 32'h2000_0014, 4'hF, 32'h2222_2222, 1'b0, 32'h0},
    '{1'b0, 1'b0, 32'h2100_0000, 4'hF, 32'h0, 1'b0, 32'h1111_1111},
    '{1'b0, 1'b0, 32'h2101_0004, 4'hF, 32'h0, 1'b0, 32'h2222_2222},
    '{1'b0, 1'b1, 32'h2003_FFFC, 4'hF, 32'h3333_3333, 1'b0, 32'h0},
    '{1'b0, 1'b0, 32'h2103_FFFC, 4'hF, 32'h0, 1'b0, 32'h3333_3333},
    '{1'b0, 1'b1, 32'h2000_0000, 4'h1, 32'hAAAA_AAFF, 1'b0, 32'h0},
    '{1'b0, 1'b0, 32'h2000_0000, 4'hF, 32'h0, 1'b0, 32'h1111_11FF},
    '{1'b0, 1'b1, 32'h2004_0000, 4'hF, 32'h4444_4444, 1'b0, 32'h0},
    '{1'b0, 1'b1, 32'h2004_1000, 4'hF, 32'h5555_5555, 1'b0, 32'h0},
    '{1'b0, 1'b0, 32'h2004_0000, 4'hF, 32'h0, 1'b0, 32'h4444_4444},
    '{1'b0, 1'b0, 32'h2004_1000, 4'hF, 32'h0, 1'b0, 32'h5555_5555},
    '{1'b0, 1'b0, 32'h0000_0004, 4'hF, 32'h0, 1'b0, 32'h5A3C_0001},
    '{1'b0, 1'b1, 32'h0000_0004, 4'hF, 32'hFFFF_FFFF, 1'b0, 32'h0},
    '{1'b0, 1'b0, 32'h0000_0004, 4'hF, 32'h0, 1'b0, 32'h5A3C_0001},
    '{1'b0, 1'b0, 32'h0000_3FFC, 4'hF, 32'h0, 1'b0, 32'h5A3C_0FFF},
    '{1'b0, 1'b0, 32'h0000_4000, 4'hF, 32'h0, 1'b1, 32'h0},
    '{1'b0, 1'b1, 32'h2004_2000, 4'hF, 32'h0, 1'b1, 32'h0},
    '{1'b0, 1'b0, 32'h2104_0000, 4'hF, 32'h0, 1'b1, 32'h0},
    '{1'b0, 1'b1, 32'h5010_0FFC, 4'hF, 32'h6666_6666, 1'b0, 32'h0},
    '{1'b0, 1'b0, 32'h5010_0FFC, 4'hF, 32'h0, 1'b0, 32'h6666_6666},
    '{1'b1, 1'b1, 32'h1500_3FFC, 4'hF, 32'h7777_7777, 1'b1, 32'h0},
    '{1'b0, 1'b1, 32'h1500_3FFC, 4'hF, 32'h7777_7777, 1'b0, 32'h0},
    '{1'b0, 1'b0, 32'h15FF_FFFC, 4'hF, 32'h0, 1'b0, 32'h7777_7777}
  };
  localparam logic [31:0] PAR [2][4] = '{
    '{32'h2000_0000, 32'h2000_0004, 32'h2000_0008, 32'h2000_000C},
    '{32'h0000_0000, 32'h2004_0000, 32'h2004_1000, 32'h5010_0FFC}
  };
  localparam logic [31:0] PAR_RD [4] = '{32'h5A3C_0000, 32'h4444_4444,
    32'h5555_5555, 32'h6666_6666};

  logic                       clk = 1'b0;
  logic                       sys_rst = 1'b1;
  logic                       cache_on = 1'b0;
  logic [NM-1:0]              start = '0;
  logic [31:0]                s_addr [NM];
  logic                       s_write [NM];
  logic [BEW-1:0]             s_be [NM];
  logic [DW-1:0]              s_wdata [NM];
  wire logic [NM-1:0]         m_req;
  wire logic [NM-1:0][31:0]   m_addr;
  wire logic [NM-1:0]         m_write;
  wire logic [NM-1:0][BEW-1:0] m_be;
  wire logic [NM-1:0][DW-1:0] m_wdata;
  wire logic [NM-1:0]         got_err;
  wire logic [DW-1:0]         got_rd [NM];
  logic      [NM-1:0]         m_done;
  logic      [NM-1:0]         m_err;
  logic      [NM-1:0][DW-1:0] m_rdata;
  int                         err_count = 0;
  int                         tests_run = 0;
  int                         cyc = 0;
  logic      [NM-1:0]         seen;

  always #2.5 clk = ~clk;

  obd_mem_decoder dut_u (.clk(clk), .sys_rst(sys_rst), .m_req(m_req), .m_addr(m_addr),
    .m_write(m_write), .m_be(m_be), .m_wdata(m_wdata), .cache_on(cache_on),
    .m_done(m_done), .m_err(m_err), .m_rdata(m_rdata));

  for (genvar g = 0; g < NM; g++) begin : g_m
    obd_master_model mm_u (.clk(clk), .sys_rst(sys_rst), .start(start[g]),
      .s_addr(s_addr[g]), .s_write(s_write[g]), .s_be(s_be[g]), .s_wdata(s_wdata[g]),
      .done(m_done[g]), .err(m_err[g]), .rdata(m_rdata[g]), .req(m_req[g]),
      .addr(m_addr[g]), .write(m_write[g]), .be(m_be[g]), .wdata(m_wdata[g]),
      .got_err(got_err[g]), .got_rdata(got_rd[g]));
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic put(input int m, input logic [31:0] a, input logic w, input logic [31:0] d);
    s_addr[m] = a;
    s_write[m] = w;
    s_be[m] = 4'hF;
    s_wdata[m] = d;
  endtask : put

  // start is sampled by the models on falling edges, so it moves on rising ones
  task automatic go(input logic [NM-1:0] mask);
    @(posedge clk);
    start <= mask;
    @(posedge clk);
    start <= '0;
  endtask : go

  task automatic wait_idle(input int m);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (m_req[m] === 1'b1 && n < 20);
    if (n >= 20) cmp(32'h1, 32'h0, "access never finished");
  endtask : wait_idle

  task automatic tally_and_finish();
    $display("Checks run %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    for (int m = 0; m < NM; m++) put(m, 32'h0, 1'b0, 32'h0);
    repeat (5) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    cmp({24'h0, m_done, m_err}, 32'h0, "flags after reset");
    cmp(m_rdata[0], 32'h0, "read data after reset");
    for (int i = 0; i < NROW; i++) begin
      @(negedge clk);
      cache_on = ROWS[i].cache;
      put(0, ROWS[i].addr, ROWS[i].wr, ROWS[i].wd);
      s_be[0] = ROWS[i].be;
      go(4'h1);
      wait_idle(0);
      cmp({31'h0, got_err[0]}, {31'h0, ROWS[i].err}, "fault flag");
      if (!ROWS[i].wr && !ROWS[i].err) cmp(got_rd[0], ROWS[i].rd, "read data");
    end
    // four masters on distinct banks all finish in the first cycle
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < NM; m++) put(m, PAR[s][m], 1'b0, 32'h0);
      go(4'hF);
      @(negedge clk);
      cmp({28'h0, m_done}, 32'hF, "parallel completion");
      cmp({28'h0, m_err}, 32'h0, "parallel fault");
      for (int m = 0; m < NM; m++) begin
        if (s == 1) cmp(m_rdata[m], PAR_RD[m], "parallel read data");
      end
      repeat (2) @(negedge clk);
    end
    // three masters on bank 0: one grant per cycle, nobody lost
    put(0, 32'h2000_0000, 1'b0, 32'h0);
    put(1, 32'h2000_0010, 1'b0, 32'h0);
    put(2, 32'h2100_0020, 1'b0, 32'h0);
    go(4'h7);
    seen = '0;
    for (int k = 0; k < 3; k++) begin
      @(negedge clk);
      cmp({28'h0, m_done & (m_done - 4'h1)}, 32'h0, "single grant");
      seen = seen | m_done;
    end
    cmp({28'h0, seen}, 32'h7, "all contenders served");
    repeat (3) @(negedge clk);
    // cache-as-memory read straight after a write waits one cycle
    put(0, 32'h1500_0020, 1'b1, 32'h8888_8888);
    put(1, 32'h1500_0020, 1'b0, 32'h0);
    @(posedge clk);
    start <= 4'h1;
    @(posedge clk);
    start <= 4'h2;
    @(posedge clk);
    start <= '0;
    @(negedge clk);
    cmp({31'h0, m_done[1]}, 32'h0, "no forwarding stall");
    @(negedge clk);
    cmp({31'h0, m_done[1]}, 32'h1, "read after write done");
    cmp(m_rdata[1], 32'h8888_8888, "read after write data");
    repeat (3) @(negedge clk);
    tally_and_finish();
  end
endmodule : onchip_memory_bank_decoder_test
